// ===== logic/cms_pkg.sv
/*
 * cms_pkg: constants, types and carriers of the chipmode swap and sfr
 * select block. Assumes a single 250 MHz core clock (mclk) and that the
 * core delivers its timing marks on that clock.
 */
package cms_pkg;

    // apb register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] WDT_CNT_OFS   = 8'h08;

    // control register fields
    localparam int CTRL_SWAP_BIT   = 0;
    localparam int CTRL_PRGEN_BIT  = 1;
    localparam int CTRL_COMMIT_BIT = 2;
    localparam int CTRL_MAP_BIT    = 3;
    localparam int CTRL_DIR_BIT    = 4;
    localparam int CTRL_WDTEN_BIT  = 5;

    // status register fields
    localparam int STAT_MODE_LSB    = 0;
    localparam int STAT_PENDING_BIT = 2;
    localparam int STAT_DIR_BIT     = 3;
    localparam int STAT_WDTRST_BIT  = 4;

    // boundaries after commit before the new mode applies
    localparam logic [1:0] MODE_DELAY_BOUNDS = 2'h2;
    // phase ticks after setting direction select before it clears
    localparam logic [1:0] DIR_CLEAR_TICKS   = 2'h2;

    // watchdog figures
    localparam logic [15:0] WDT_RAM_RESET_POINT = 16'h7FFC;
    localparam logic [15:0] WDT_NORMAL_TOP      = 16'hFFFF;
    localparam logic [15:0] WDT_RELOAD          = 16'h0000;

    // reset values
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_NORMAL     = 2'b00,
        MODE_ONCHIP_RAM = 2'b01,
        MODE_BOOTSTRAP  = 2'b10,
        MODE_PROGRAM    = 2'b11
    } cms_mode_t;

    // timing marks and requests from the core, all on mclk
    typedef struct packed {
        logic       instrEnd;
        logic       phaseTick;
        logic       codeFetch;
        logic       dataRead;
        logic       wdtTick;
        logic       wdtRefresh;
        logic [7:0] sfrAddr;
    } cms_core_t;

    // sfr access selects back to the core
    typedef struct packed {
        logic mappedArea;
        logic directionRegs;
        logic bitAddressable;
    } cms_sfr_sel_t;

    typedef struct packed {
        cms_mode_t    activeMode;
        cms_mode_t    newMode;
        logic         pending;
        logic [1:0]   boundCnt;
        logic         mapSel;
        logic         dirSel;
        logic [1:0]   dirTicks;
        logic         wdtEn;
        logic [15:0]  wdtCnt;
        logic         wdtRstPulse;
        logic         wdtRstSeen;
        logic         progFetchN;
        logic         dataReadN;
        cms_sfr_sel_t sfrSel;
        logic [31:0]  rdata;
        logic         slverr;
    } cms_state_t;

endpackage : cms_pkg

// ===== logic/cms_chipmode_ctrl.sv
/*
 * cms_chipmode_ctrl: chipmode register, strobe pin swap, chipmode watchdog
 * gating and sfr area select, with an apb slave for software.
 * Assumes the core gives one-cycle marks on mclk for instruction ends and
 * machine-cycle phase ticks, and that software keeps the jump sequence.
 */
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps

module cms_chipmode_ctrl
    import cms_pkg::*;
(
    // clock, reset, enable
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         ce,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // core side
    input  wire cms_core_t    core,
    output cms_sfr_sel_t      sfrSel,
    output logic              wdtResetPulse,
    output cms_mode_t         chipMode,
    // external strobe pins
    output logic              progFetchStrobeN,
    output logic              dataReadStrobeN
);

    cms_state_t s_q;
    cms_state_t s_d;

    logic       setupPhase;
    logic       accessWrite;
    logic       ctrlWrite;
    logic       wdtHalted;
    logic       swapOn;
    logic [31:0] readMux;
    logic       addrHit;

    assign setupPhase  = psel & ~penable;
    assign accessWrite = psel & penable & pwrite & ce;
    assign ctrlWrite   = accessWrite & (paddr == CTRL_OFS);
    // zero wait states while enabled; a frozen block stalls the bus
    assign pready      = penable & ce;

    assign swapOn    = s_q.activeMode[0];
    assign wdtHalted = (s_q.activeMode == MODE_BOOTSTRAP) || (s_q.activeMode == MODE_PROGRAM);

    always_comb begin
        readMux = 32'h0000_0000;
        addrHit = 1'b1;
        unique case (paddr)
            CTRL_OFS: begin
                readMux[CTRL_SWAP_BIT]  = s_q.newMode[0];
                readMux[CTRL_PRGEN_BIT] = s_q.newMode[1];
                readMux[CTRL_MAP_BIT]   = s_q.mapSel;
                readMux[CTRL_DIR_BIT]   = s_q.dirSel;
                readMux[CTRL_WDTEN_BIT] = s_q.wdtEn;
            end
            STATUS_OFS: begin
                readMux[STAT_MODE_LSB +: 2] = s_q.activeMode;
                readMux[STAT_PENDING_BIT]   = s_q.pending;
                readMux[STAT_DIR_BIT]       = s_q.dirSel;
                readMux[STAT_WDTRST_BIT]    = s_q.wdtRstSeen;
            end
            WDT_CNT_OFS: begin
                readMux[15:0] = s_q.wdtCnt;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.wdtRstPulse = 1'b0;

        // read data and error are captured in the setup cycle
        if (setupPhase) begin
            s_d.rdata  = pwrite ? 32'h0000_0000 : readMux;
            s_d.slverr = ~addrHit;
        end

        if (s_q.pending && core.instrEnd) begin
            if (s_q.boundCnt == MODE_DELAY_BOUNDS - 2'h1) begin
                s_d.activeMode = s_q.newMode;
                s_d.pending    = 1'b0;
                s_d.boundCnt   = 2'h0;
            end else begin
                s_d.boundCnt = s_q.boundCnt + 2'h1;
            end
        end
        // mode bits change only together with a commit; plain writes are dropped
        if (ctrlWrite && pwdata[CTRL_COMMIT_BIT]) begin
            s_d.newMode  = cms_mode_t'({pwdata[CTRL_PRGEN_BIT], pwdata[CTRL_SWAP_BIT]});
            s_d.pending  = 1'b1;
            s_d.boundCnt = 2'h0;
        end

        if (ctrlWrite) begin
            s_d.mapSel = pwdata[CTRL_MAP_BIT];
        end

        if (s_q.dirSel && core.phaseTick) begin
            if (s_q.dirTicks == DIR_CLEAR_TICKS - 2'h1) begin
                s_d.dirSel   = 1'b0;
                s_d.dirTicks = 2'h0;
            end else begin
                s_d.dirTicks = s_q.dirTicks + 2'h1;
            end
        end
        // a set in the clearing cycle wins and restarts the count
        if (ctrlWrite && pwdata[CTRL_DIR_BIT]) begin
            s_d.dirSel   = 1'b1;
            s_d.dirTicks = 2'h0;
        end

        // watchdog stays enabled once enabled, until reset
        if (ctrlWrite && pwdata[CTRL_WDTEN_BIT]) begin
            s_d.wdtEn = 1'b1;
        end
        if (s_q.wdtEn) begin
            if (core.wdtTick && !wdtHalted) begin
                s_d.wdtCnt = s_q.wdtCnt + 16'h0001;
            end
            if (s_q.activeMode == MODE_NORMAL) begin
                if (core.wdtRefresh) begin
                    s_d.wdtCnt = WDT_RELOAD;
                end else if (core.wdtTick && s_q.wdtCnt == WDT_NORMAL_TOP) begin
                    s_d.wdtRstPulse = 1'b1;
                    s_d.wdtCnt      = WDT_RELOAD;
                end
            end
            if (s_q.activeMode == MODE_ONCHIP_RAM) begin
                if (s_q.wdtCnt == WDT_RAM_RESET_POINT) begin
                    s_d.wdtRstPulse = 1'b1;
                    s_d.wdtCnt      = WDT_RELOAD;
                end
            end
        end
        // sticky flag, readable after the reset pulse; writing one to its status bit clears, a pulse in that cycle wins
        if (accessWrite && paddr == STATUS_OFS && pwdata[STAT_WDTRST_BIT]) begin
            s_d.wdtRstSeen = 1'b0;
        end
        if (s_d.wdtRstPulse) begin
            s_d.wdtRstSeen = 1'b1;
        end

        s_d.progFetchN = swapOn ? ~core.dataRead : ~core.codeFetch;
        s_d.dataReadN  = swapOn ? ~core.codeFetch : ~core.dataRead;

        s_d.sfrSel.mappedArea    = s_q.mapSel;
        s_d.sfrSel.directionRegs = s_q.dirSel;
        s_d.sfrSel.bitAddressable = core.sfrAddr[7] && (core.sfrAddr[2:0] == 3'h0);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '{
                activeMode : MODE_NORMAL,
                newMode    : MODE_NORMAL,
                pending    : 1'b0,
                boundCnt   : 2'h0,
                mapSel     : 1'b0,
                dirSel     : 1'b0,
                dirTicks   : 2'h0,
                wdtEn      : 1'b0,
                wdtCnt     : WDT_RELOAD,
                wdtRstPulse: 1'b0,
                wdtRstSeen : 1'b0,
                progFetchN : 1'b1,
                dataReadN  : 1'b1,
                sfrSel     : '{mappedArea: 1'b0, directionRegs: 1'b0, bitAddressable: 1'b0},
                rdata      : RDATA_RST,
                slverr     : 1'b0
            };
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign prdata           = s_q.rdata;
    assign pslverr          = s_q.slverr & penable;
    assign sfrSel           = s_q.sfrSel;
    assign wdtResetPulse    = s_q.wdtRstPulse;
    assign chipMode         = s_q.activeMode;
    assign progFetchStrobeN = s_q.progFetchN;
    assign dataReadStrobeN  = s_q.dataReadN;

endmodule : cms_chipmode_ctrl

// ===== bench/cms_chipmode_ctrl_properties.sv
/* checker of the chipmode block, seeing only its ports.
   assumes it is bound onto cms_chipmode_ctrl and ce stays high. */
`timescale 1ns/1ps
module cms_chipmode_ctrl_properties
    import cms_pkg::*;
(
    // clock and reset
    input wire logic         mclk,
    input wire logic         rst,
    // apb
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    // core and pins
    input wire cms_core_t    core,
    input wire cms_sfr_sel_t sfrSel,
    input wire logic         wdtResetPulse,
    input wire cms_mode_t    chipMode,
    input wire logic         progFetchStrobeN,
    input wire logic         dataReadStrobeN
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic mapClr;
    assign mapClr = psel && penable && pwrite && paddr == CTRL_OFS && !pwdata[CTRL_MAP_BIT];
    sequence s_ctrlWr;
        psel && penable && pwrite && paddr == CTRL_OFS;
    endsequence
    sequence s_commit;
        s_ctrlWr ##0 pwdata[CTRL_COMMIT_BIT];
    endsequence
    a_swap_pins: assert property (chipMode[0] && $past(chipMode[0]) |->
        progFetchStrobeN == !$past(core.dataRead) && dataReadStrobeN == !$past(core.codeFetch))
        else $error("swapped strobe pins wrong");
    a_home_pins: assert property (!chipMode[0] && !$past(chipMode[0]) |->
        progFetchStrobeN == !$past(core.codeFetch) && dataReadStrobeN == !$past(core.dataRead))
        else $error("home strobe pins wrong");
    a_mode_boundary: assert property ($changed(chipMode) |-> $past(core.instrEnd))
        else $error("mode changed off a boundary");
    a_commit_hold: assert property (s_commit |=> $stable(chipMode) [*2])
        else $error("mode changed too soon");
    a_map_set: assert property (s_ctrlWr ##0 pwdata[CTRL_MAP_BIT] |->
        ##[1:2] sfrSel.mappedArea) else $error("mapped select not applied");
    a_map_held: assert property ($fell(sfrSel.mappedArea) |->
        $past(mapClr) || $past(mapClr, 2)) else $error("mapped select cleared by itself");
    a_dir_tick: assert property ($fell(sfrSel.directionRegs) |->
        $past(core.phaseTick) || $past(core.phaseTick, 2)) else $error("direction cleared early");
    a_bit_addr: assert property (sfrSel.bitAddressable ==
        ($past(core.sfrAddr[7]) && $past(core.sfrAddr[2:0]) == 3'h0)) else $error("bit sel wrong");
    a_wdt_frozen: assert property (chipMode[1] && $past(chipMode[1]) |-> !wdtResetPulse)
        else $error("watchdog reset while frozen");
endmodule : cms_chipmode_ctrl_properties

// ===== bench/cms_ext_mem.sv
/* external code rom and data sram seen through their read enables.
   assumes active-low enables taken straight from the strobe pins. */
`timescale 1ns/1ps
module cms_ext_mem (
    // enables
    input wire logic   romOeN,
    input wire logic   ramRdN,
    // data buses
    output logic [7:0] romBus,
    output logic [7:0] ramBus
);
    // released bus shows the inverse so a stale word never passes
    assign romBus = romOeN ? 8'h3C : 8'hC3;
    assign ramBus = ramRdN ? 8'hA5 : 8'h5A;
endmodule : cms_ext_mem

// ===== bench/cms_chipmode_ctrl_test.sv
/* bench of the chipmode block: apb tasks, core marks, pin and memory checks.
   assumes the checker and memory model are compiled first; ce held high. */
`timescale 1ns/1ps
module cms_chipmode_ctrl_test
    import cms_pkg::*;
;
    logic         mclk, rst, ce, psel, penable, pwrite, pready, pslverr, perr, wdtPulse;
    logic         progN, dataN;
    logic [7:0]   paddr, romBus, ramBus;
    logic [31:0]  pwdata, prdata, q;
    cms_core_t    core;
    cms_sfr_sel_t sfrSel;
    cms_mode_t    chipMode;
    int           fails, compares, n;
    cms_chipmode_ctrl i_dut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .core(core), .sfrSel(sfrSel), .wdtResetPulse(wdtPulse),
        .chipMode(chipMode), .progFetchStrobeN(progN), .dataReadStrobeN(dataN));
    cms_ext_mem i_mem (.romOeN(progN), .ramRdN(dataN), .romBus(romBus), .ramBus(ramBus));
    always #2 mclk = ~mclk;
    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rdc
    // one mark: 0 instruction end, 1 phase tick
    task automatic pul(input int w);
        @(posedge mclk);
        if (w == 0) core.instrEnd <= 1'b1;
        else core.phaseTick <= 1'b1;
        @(posedge mclk);
        core.instrEnd <= 1'b0;
        core.phaseTick <= 1'b0;
    endtask : pul
    task automatic tk(input int k);
        @(posedge mclk);
        core.wdtTick <= 1'b1;
        repeat (k) @(posedge mclk);
        core.wdtTick <= 1'b0;
    endtask : tk
    // e is {fetch pin, data pin}; low pin means its memory answers
    task automatic pins(input logic cf, input logic dr, input logic [1:0] e);
        @(posedge mclk);
        core.codeFetch <= cf;
        core.dataRead <= dr;
        repeat (2) @(negedge mclk);
        chk("pins", e, {progN, dataN});
        chk("mem", {~e[1], ~e[0]}, {romBus === 8'hC3, ramBus === 8'h5A});
    endtask : pins
    task automatic sel(input logic [7:0] a, input logic e);
        @(posedge mclk);
        core.sfrAddr <= a;
        repeat (2) @(negedge mclk);
        chk("bitSel", e, sfrSel.bitAddressable);
    endtask : sel
    initial begin
        repeat (50000) @(posedge mclk);
        fails++;
        close_out();
    end
    initial begin
        {mclk, ce, rst, psel, penable, pwrite, paddr, pwdata, core} = '0;
        ce = 1'b1;
        rst = 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rdc("ctrl", CTRL_OFS, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("slverr", 1'b1, perr);
        pins(1'b1, 1'b0, 2'b01);
        pins(1'b0, 1'b1, 2'b10);
        $display("end reset and home pins");
        apb(1'b1, CTRL_OFS, 32'h5);
        pul(0);
        rdc("pending", STATUS_OFS, 32'h4);
        pul(0);
        rdc("swapped", STATUS_OFS, 32'h1);
        chk("chipMode", MODE_ONCHIP_RAM, chipMode);
        pins(1'b1, 1'b0, 2'b10);
        pins(1'b0, 1'b1, 2'b01);
        $display("end swap");
        apb(1'b1, CTRL_OFS, 32'h20);
        core.wdtRefresh <= 1'b1;
        tk(100);
        rdc("ramCount", WDT_CNT_OFS, 32'h64);
        @(posedge mclk);
        core.wdtTick <= 1'b1;
        for (n = 0; n < 40000 && wdtPulse !== 1'b1; n++) @(negedge mclk);
        @(posedge mclk);
        core.wdtTick <= 1'b0;
        chk("resetAt", 1'b1, n >= 32664 && n <= 32668);
        rdc("seen", STATUS_OFS, 32'h11);
        $display("end ram watchdog");
        apb(1'b1, CTRL_OFS, 32'h4);
        pul(0);
        pul(0);
        tk(5);
        core.wdtRefresh <= 1'b0;
        tk(3);
        rdc("normalCount", WDT_CNT_OFS, 32'h3);
        apb(1'b1, CTRL_OFS, 32'h6);
        pul(0);
        pul(0);
        tk(50);
        rdc("bootCount", WDT_CNT_OFS, 32'h3);
        rdc("boot", STATUS_OFS, 32'h12);
        chk("chipMode", MODE_BOOTSTRAP, chipMode);
        // sticky reset flag cleared by writing one to it
        apb(1'b1, STATUS_OFS, 32'h10);
        rdc("seenClr", STATUS_OFS, 32'h2);
        $display("end watchdog modes");
        apb(1'b1, CTRL_OFS, 32'h8);
        repeat (50) @(negedge mclk);
        chk("mapped", 1'b1, sfrSel.mappedArea);
        apb(1'b1, CTRL_OFS, 32'h10);
        repeat (2) @(negedge mclk);
        chk("mapOff", 2'b01, {sfrSel.mappedArea, sfrSel.directionRegs});
        pul(1);
        @(negedge mclk);
        chk("dirHeld", 1'b1, sfrSel.directionRegs);
        pul(1);
        // select clears on the tick edge, output follows one edge later
        repeat (2) @(negedge mclk);
        chk("dirOff", 1'b0, sfrSel.directionRegs);
        $display("end selects");
        sel(8'h88, 1'b1);
        sel(8'hF8, 1'b1);
        sel(8'h89, 1'b0);
        sel(8'h08, 1'b0);
        $display("end bit select");
        close_out();
    end
endmodule : cms_chipmode_ctrl_test
bind cms_chipmode_ctrl cms_chipmode_ctrl_properties i_prop (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .core(core),
    .sfrSel(sfrSel), .wdtResetPulse(wdtResetPulse), .chipMode(chipMode),
    .progFetchStrobeN(progFetchStrobeN), .dataReadStrobeN(dataReadStrobeN));
